// [sld_defs.svh]
/*
  Constants for the serial shift latch sink driver: widths, reset values
  and sink drive level. Assumes inclusion by bare name from the package
  and the sld_top module.
*/
`ifndef SLD_DEFS_SVH
`define SLD_DEFS_SVH

// --------------------------------------------------------------
// Widths, reset values and sink drive level
// --------------------------------------------------------------
`define SLD_WIDTH 8
`define SLD_STAGE_RST 8'h00
`define SLD_SYNC_RST 1'b0
`define SLD_SINK_DRIVE 8'h00

`endif

// [sld_pkg.sv]
/*
  Types shared by the serial shift latch sink driver.
  Assumes sld_defs.svh is on the include path.
*/
`default_nettype none

`include "sld_defs.svh"

package sld_pkg;
  typedef logic [`SLD_WIDTH-1:0] sld_byte_t;
endpackage

`default_nettype wire

// [sld_sync.sv]
/*
  Two flip-flop synchroniser for a group of pin levels.
  Assumes inputs are asynchronous to clk_sys; output lags by two edges.
*/
`timescale 1ns/1ns
`default_nettype none

module sld_sync
  import sld_pkg::*;
#(
  parameter int WIDTH = 5
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] firstFf;
  logic [WIDTH-1:0] next_firstFf;
  logic [WIDTH-1:0] next_syncOut;

  always_comb
  begin
    next_firstFf = pinIn;
    next_syncOut = firstFf;
  end

  // First stage read only by the second one
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      firstFf <= '0;
      syncOut <= '0;
    end
    else
    begin
      firstFf <= next_firstFf;
      syncOut <= next_syncOut;
    end
  end

endmodule

`default_nettype wire

// [sld_top.sv]
/*
  Serial shift register, transparent/hold latch and eight open-drain sink
  drivers with a cascade output. Assumes shift clock, data, latch, enable
  and clear arrive as asynchronous pins; shift clock well below clk_sys/4.
*/
// How it works
// [RULE1] Eight flops form the serial shift chain, stepped by the shift clock.
// [RULE2] Each shift clock rise loads the data pin into stage one and shifts.
// [RULE3] A second set of eight flops takes the chain and drives the sinks.
// [RULE4] The cascade output shows the eighth shift stage.
// [RULE5] Systems chain devices by wiring cascade output to the next data input.
// [RULE6] Latch control low holds the sink state whatever the chain does.
// [RULE7] Latch control high makes the latch follow the chain.
// [RULE8] Enable pin high turns all eight sinks off.
// [RULE9] Enable pin low drives the sinks from the latched data.
// [RULE10] Clear low resets the shift chain and the latch.
// [RULE11] Clear low turns off all sinks and the cascade output.
// [RULE12] First bit in appears on sink one, then moves toward sink eight.
// [RULE13] A sink pin level is the inverse of its stored data bit.
// [RULE14] The system holds clear low before and during power up.
// [RULE15] Clear and enable gate the outputs without waiting for a clock.
`timescale 1ns/1ns
`default_nettype none

`include "sld_defs.svh"

module sld_top
  import sld_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic shiftClk,
  input wire logic serialDataIn,
  input wire logic latchCtl,
  input wire logic outputEnableN,
  input wire logic clearN,
  output logic cascadeOut,
  output logic [`SLD_WIDTH-1:0] sinkOut,
  output logic [`SLD_WIDTH-1:0] sinkOe_n
);

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  // Enable skips the sync: it gates the sinks straight from its pin
  logic [3:0] syncBus;
  logic sckS;
  logic dataS;
  logic latchS;
  logic clrNS;

  sld_sync #(.WIDTH(4)) u_sync
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pinIn({shiftClk, serialDataIn, latchCtl, clearN}),
    .syncOut(syncBus)
  );

  assign sckS = syncBus[3];
  assign dataS = syncBus[2];
  assign latchS = syncBus[1];
  assign clrNS = syncBus[0];

  // --------------------------------------------------------------
  // Shift chain and latch
  // --------------------------------------------------------------
  sld_byte_t stage;
  sld_byte_t hold;
  logic sckPrev;
  sld_byte_t next_stage;
  sld_byte_t next_hold;
  logic next_sckPrev;
  logic shiftRise;

  // Data and clock share the same sync delay, so setup is preserved
  assign shiftRise = sckS & ~sckPrev;

  always_comb
  begin
    next_sckPrev = sckS;
    next_stage = stage;
    next_hold = hold;
    if (!clrNS)
    begin
      next_stage = `SLD_STAGE_RST; // RULE10
      next_hold = `SLD_STAGE_RST; // RULE10
    end
    else
    begin
      if (shiftRise)
      begin
        next_stage = {stage[`SLD_WIDTH-2:0], dataS}; // RULE1 RULE2 RULE12
      end
      if (latchS)
      begin
        next_hold = stage; // RULE3 RULE7
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage <= `SLD_STAGE_RST;
      hold <= `SLD_STAGE_RST;
      sckPrev <= `SLD_SYNC_RST;
    end
    else
    begin
      stage <= next_stage;
      hold <= next_hold; // RULE6
      sckPrev <= next_sckPrev;
    end
  end

  // --------------------------------------------------------------
  // Output drivers
  // --------------------------------------------------------------
  // Raw pins gate here on purpose: off must not wait for a clock
  logic sinkEnable;

  assign sinkEnable = clearN & ~outputEnableN; // RULE15 RULE8 RULE11
  // Open drain: pin pulled low for a stored one, so level is inverted
  assign sinkOut = `SLD_SINK_DRIVE; // RULE13
  assign sinkOe_n = ~(hold & {`SLD_WIDTH{sinkEnable}}); // RULE9 RULE13
  assign cascadeOut = stage[`SLD_WIDTH-1] & clearN; // RULE4 RULE11

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sequence s_firstOne;
    shiftRise && dataS && clrNS && latchS;
  endsequence

  sequence s_keepGoing;
    (clrNS && latchS);
  endsequence

  property p_shiftStep;
    @(posedge clk_sys) disable iff (!rst_b)
    (shiftRise && clrNS) |=> stage == {$past(stage[6:0]), $past(dataS)};
  endproperty
  a_shiftStep: assert property (p_shiftStep) // RULE2
    else $error("shift chain did not step on shift clock rise");

  property p_shiftIdle;
    @(posedge clk_sys) disable iff (!rst_b)
    (!shiftRise && clrNS) |=> $stable(stage);
  endproperty
  a_shiftIdle: assert property (p_shiftIdle) // RULE1
    else $error("shift chain moved without a shift clock rise");

  property p_latchHold;
    @(posedge clk_sys) disable iff (!rst_b)
    (!latchS && clrNS) |=> $stable(hold);
  endproperty
  a_latchHold: assert property (p_latchHold) // RULE6
    else $error("latch changed while latch control low");

  property p_latchFollow;
    @(posedge clk_sys) disable iff (!rst_b)
    (latchS && clrNS) |=> hold == $past(stage);
  endproperty
  a_latchFollow: assert property (p_latchFollow) // RULE7
    else $error("latch did not follow chain while transparent");

  property p_cascade;
    @(posedge clk_sys) disable iff (!rst_b)
    clearN |-> cascadeOut == stage[7];
  endproperty
  a_cascade: assert property (p_cascade) // RULE4
    else $error("cascade output differs from last stage");

  property p_disabled;
    @(posedge clk_sys) disable iff (!rst_b)
    outputEnableN |-> (&sinkOe_n);
  endproperty
  a_disabled: assert property (p_disabled) // RULE8
    else $error("sink driven while enable pin high");

  property p_enabled;
    @(posedge clk_sys) disable iff (!rst_b)
    (clearN && !outputEnableN) |-> (sinkOe_n == ~hold) && (sinkOut == 8'h00);
  endproperty
  a_enabled: assert property (p_enabled) // RULE9
    else $error("sinks do not show inverted latch data");

  property p_clearRegs;
    @(posedge clk_sys) disable iff (!rst_b)
    !clrNS |=> (stage == 8'h00) && (hold == 8'h00);
  endproperty
  a_clearRegs: assert property (p_clearRegs) // RULE10
    else $error("clear did not reset chain and latch");

  property p_clearOut;
    @(posedge clk_sys) disable iff (!rst_b)
    !clearN |-> (&sinkOe_n) && !cascadeOut;
  endproperty
  a_clearOut: assert property (p_clearOut) // RULE11
    else $error("outputs active while clear low");

  property p_firstToSinkOne;
    @(posedge clk_sys) disable iff (!rst_b)
    s_firstOne ##1 s_keepGoing |=> hold[0];
  endproperty
  a_firstToSinkOne: assert property (p_firstToSinkOne) // RULE12
    else $error("first bit did not reach sink one");

  property p_lastStage;
    @(posedge clk_sys) disable iff (!rst_b)
    (shiftRise && clrNS) |=> stage[7] == $past(stage[6]);
  endproperty
  a_lastStage: assert property (p_lastStage) // RULE12
    else $error("bit did not advance toward sink eight");

  // Sinks only ever pull low; the off level comes from the pull-up
  property p_sinkLevel;
    @(posedge clk_sys) disable iff (!rst_b)
    sinkOut == 8'h00;
  endproperty
  a_sinkLevel: assert property (p_sinkLevel) // RULE13
    else $error("sink drive level not low");

  property p_offNoClock;
    @(posedge clk_sys) disable iff (!rst_b)
    (outputEnableN || !clearN) |-> (&sinkOe_n);
  endproperty
  a_offNoClock: assert property (p_offNoClock) // RULE15
    else $error("sinks not off while enable high or clear low");

endmodule

`default_nettype wire

// [sld_host_model.sv]
/*
  Host model: shifts a byte out, d[7] first, on the shift clock pin.
  Assumes clk_sys at 50 MHz; one shift period is 8 clk_sys cycles.
*/
`timescale 1ns/1ns
`default_nettype none

module sld_host_model
  import sld_pkg::*;
(
  input wire logic clk_sys,
  input wire logic go,
  input wire sld_byte_t txByte,
  output logic shiftClk,
  output logic serialDataIn,
  output logic busy
);
  sld_byte_t sh;
  int unsigned ph;

  initial
  begin
    shiftClk = 1'b0;
    serialDataIn = 1'b0;
    busy = 1'b0;
    sh = 8'h00;
    ph = 0;
  end

  // Data moves mid-low, well clear of the rise; clock idles low
  always @(negedge clk_sys)
  begin
    if (!busy && go)
    begin
      busy <= 1'b1;
      sh <= txByte;
      ph <= 0;
    end
    else if (busy)
    begin
      ph <= ph + 1;
      if (ph % 8 == 0)
        shiftClk <= 1'b0;
      if (ph % 8 == 1)
        serialDataIn <= sh[7];
      if (ph % 8 == 4)
      begin
        shiftClk <= 1'b1;
        sh <= sh << 1;
      end
      if (ph == 64)
      begin
        busy <= 1'b0;
        // Released pin falls to its pull-down level
        serialDataIn <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// [sld_tb_top.sv]
/*
  Self-checking bench for sld_top with a host model on the serial pins.
  Assumes sld_pkg and sld_host_model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module sld_tb_top
  import sld_pkg::*;
;
  logic clk_sys, rst_b, latchCtl, outputEnableN, clearN, go, busy;
  logic shiftClk, serialDataIn, cascadeOut;
  sld_byte_t txByte, sinkOut, sinkOe_n, d;
  sld_byte_t nextSinkOe_n, prev;
  int n_errors, comparisons, i;

  sld_top u_sld_top (.clk_sys(clk_sys), .rst_b(rst_b), .shiftClk(shiftClk),
    .serialDataIn(serialDataIn), .latchCtl(latchCtl), .outputEnableN(outputEnableN),
    .clearN(clearN), .cascadeOut(cascadeOut), .sinkOut(sinkOut), .sinkOe_n(sinkOe_n));
  sld_host_model u_sld_host_model (.clk_sys(clk_sys), .go(go), .txByte(txByte),
    .shiftClk(shiftClk), .serialDataIn(serialDataIn), .busy(busy));
  // Second device on the same shift clock, fed from the cascade pin
  sld_top u_sld_top_next (.clk_sys(clk_sys), .rst_b(rst_b), .shiftClk(shiftClk),
    .serialDataIn(cascadeOut), .latchCtl(latchCtl), .outputEnableN(outputEnableN),
    .clearN(clearN), .cascadeOut(), .sinkOut(), .sinkOe_n(nextSinkOe_n));

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input sld_byte_t exp, input sld_byte_t got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Pins stored as ones pull low, hence the inversion
  function automatic sld_byte_t sinkExp(input sld_byte_t v);
    return ~v;
  endfunction

  task automatic send(input sld_byte_t b);
    int k;
    @(negedge clk_sys);
    txByte <= b;
    go <= 1'b1;
    @(negedge clk_sys);
    go <= 1'b0;
    @(negedge clk_sys);
    for (k = 0; k < 200 && busy === 1'b1; k++)
      @(negedge clk_sys);
    if (busy !== 1'b0)
    begin
      check("host busy", 8'h00, 8'h01);
      close_out();
    end
    // Sync, shift and latch lag
    repeat (8) @(negedge clk_sys);
  endtask

  initial
  begin
    rst_b = 1'b0;
    clearN = 1'b0;
    latchCtl = 1'b1;
    outputEnableN = 1'b0;
    go = 1'b0;
    txByte = 8'h00;
    prev = 8'h00;
    n_errors = 0;
    comparisons = 0;
    void'($urandom(26));
    repeat (16) @(negedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    check("sinkOe_n clr", 8'hFF, sinkOe_n);
    clearN <= 1'b1;
    repeat (4) @(negedge clk_sys);
    check("sinkOe_n rst", 8'hFF, sinkOe_n);
    $display("test reset done");
    for (i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : sld_byte_t'($urandom);
      send(d);
      check("sinkOe_n", sinkExp(d), sinkOe_n);
      check("cascadeOut", {7'h00, d[7]}, {7'h00, cascadeOut});
      check("sinkOut", 8'h00, sinkOut);
      check("next sinkOe_n", sinkExp(prev), nextSinkOe_n);
      prev = d;
    end
    $display("test shift done");
    latchCtl <= 1'b0;
    send(~d);
    check("held", sinkExp(d), sinkOe_n);
    latchCtl <= 1'b1;
    repeat (6) @(negedge clk_sys);
    check("follow", d, sinkOe_n);
    outputEnableN <= 1'b1;
    #1;
    check("disabled", 8'hFF, sinkOe_n);
    @(negedge clk_sys);
    outputEnableN <= 1'b0;
    #1;
    check("enabled", d, sinkOe_n);
    $display("test latch enable done");
    send(8'hFF);
    check("all on", 8'h00, sinkOe_n);
    check("next all on", sinkExp(~d), nextSinkOe_n);
    clearN <= 1'b0;
    #1;
    check("clr cascade", 8'h00, {7'h00, cascadeOut});
    check("clr sinks", 8'hFF, sinkOe_n);
    repeat (5) @(negedge clk_sys);
    clearN <= 1'b1;
    repeat (6) @(negedge clk_sys);
    check("cleared", 8'hFF, sinkOe_n);
    check("cleared cas", 8'h00, {7'h00, cascadeOut});
    $display("test clear done");
    close_out();
  end
endmodule

`default_nettype wire
